// >>> hw/gtc_core.sv
// One timer/counter: prescaler, count register and match detection.
// Assumes the external tick is already synchronised and edge-detected.
`timescale 1ns/1ps
`default_nettype none
module gtc_core
    import gtc_pkg::*;
#(
    parameter int NM = GTC_NUM_MATCH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire gtc_cfg_s cfg,
    input wire logic [NM*GTC_MCR_W-1:0] mcr,
    input wire logic ext_rise,
    input wire logic [NM-1:0][GTC_DW-1:0] mr,
    input wire logic tc_wr,
    input wire logic [GTC_DW-1:0] tc_wdata,
    output logic [GTC_DW-1:0] tc_r,
    output logic [GTC_DW-1:0] pc_r,
    output logic [NM-1:0] match_ev,
    output logic stop_ev
);

    logic tick; // One counted clock
    logic term; // Prescaler reaches its limit
    logic [NM-1:0] rst_hit; // Match asking for a restart
    logic [NM-1:0] stop_hit; // Match asking for a halt

    assign tick = cfg.enable & ~cfg.cnt_rst & (cfg.mode ? ext_rise : 1'b1);
    assign term = tick & (pc_r == cfg.prescale);
    assign stop_ev = |stop_hit;

    // Compare every match register against the count
    genvar i;
    generate
        for (i = 0; i < NM; i++) begin : g_match
            assign match_ev[i] = term & (tc_r == mr[i]);
            assign rst_hit[i] = match_ev[i] & mcr[i*GTC_MCR_W+GTC_MCR_RST];
            assign stop_hit[i] = match_ev[i] & mcr[i*GTC_MCR_W+GTC_MCR_STOP];
        end
    endgenerate

    // Prescale counter; a count write restarts the prescaler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= GTC_RST_WORD;
        end else if (ce) begin
            if (cfg.cnt_rst || tc_wr) begin
                pc_r <= GTC_RST_WORD;
            end else if (term) begin
                pc_r <= GTC_RST_WORD;
            end else if (tick) begin
                pc_r <= pc_r + GTC_DW'(1);
            end
        end
    end

    // Count register; restart beats halt, halt beats increment
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tc_r <= GTC_RST_WORD;
        end else if (ce) begin
            if (cfg.cnt_rst) begin
                tc_r <= GTC_RST_WORD;
            end else if (tc_wr) begin
                tc_r <= tc_wdata;
            end else if (term) begin
                if (|rst_hit) begin
                    tc_r <= GTC_RST_WORD;
                end else if (!(|stop_hit)) begin
                    tc_r <= tc_r + GTC_DW'(1);
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> hw/gtc_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/1ps
`default_nettype none
module gtc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage, read only by the second stage
    logic [W-1:0] meta_r;

    // Both stages freeze with the clock enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule
`default_nettype wire

// >>> hw/gtc_top.sv
// Four 32-bit timer/counters behind one AHB-Lite register slave.
// Assumes capture and external clock pins are asynchronous to hclk.
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gtc_top
    import gtc_pkg::*;
#(
    parameter int NT = GTC_NUM_TIMERS,
    parameter int NM = GTC_NUM_MATCH,
    parameter int NC = GTC_NUM_CAP,
    parameter int ND = GTC_NUM_DMA
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [GTC_DW-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [GTC_DW-1:0] hrdata,
    output logic hresp,
    input wire logic [NT*NC-1:0] cap_in,
    input wire logic [NT-1:0] ext_clk_in,
    output logic [NT*NM-1:0] match_out,
    output logic [NT*ND-1:0] dma_req,
    output logic irq
);

    // Pins passed through the synchroniser
    localparam int SW = NT*NC + NT;

    // True when a word address lands on one register of one timer
    function automatic logic reg_hit(
        input logic [GTC_ADDR_W-1:0] a,
        input logic [GTC_TSEL_W-1:0] tid,
        input logic [GTC_OFF_W-1:0] off
    );
        logic same_t;
        same_t = (a[GTC_TSEL_LSB+GTC_TSEL_W-1:GTC_TSEL_LSB] == tid);
        return same_t && (a[GTC_OFF_W-1:0] == off);
    endfunction

    // Offset of the n-th word of a register group
    function automatic logic [GTC_OFF_W-1:0] grp_off(
        input logic [GTC_OFF_W-1:0] base,
        input int n
    );
        return base + GTC_OFF_W'(n*GTC_WORD_BYTES);
    endfunction

    // Bus transaction state
    logic acc; // Address phase taken this cycle
    logic wr_pend_r; // Write data phase in progress
    logic rd_pend_r; // Read wait cycle in progress
    logic [GTC_ADDR_W-1:0] addr_r; // Latched address
    logic hreadyout_r;
    logic [GTC_DW-1:0] hrdata_r;
    logic [GTC_DW-1:0] rd_word; // Read mux result
    logic [GTC_TSEL_W-1:0] rd_t; // Timer addressed by the read

    // Synchronised pins and their previous value for edge detection
    logic [SW-1:0] pin_s;
    logic [SW-1:0] pin_prev_r;
    logic [SW-1:0] pin_rise;
    logic [SW-1:0] pin_fall;

    // Per-timer software state
    gtc_cfg_s cfg_r [NT];
    logic [NT-1:0][NM-1:0][GTC_DW-1:0] mr_r;
    logic [NT-1:0][NC-1:0][GTC_DW-1:0] cap_r;
    logic [NT-1:0][NM*GTC_MCR_W-1:0] mcr_r;
    logic [NT-1:0][NC*GTC_CCR_W-1:0] ccr_r;
    logic [NT-1:0][GTC_EMR_W-1:0] emr_r;
    logic [NT-1:0][ND-1:0] dmar_r;
    logic [NT-1:0][GTC_ST_W-1:0] status_r;
    logic [NT-1:0][GTC_ST_W-1:0] mask_r;

    // Per-timer core results
    logic [NT-1:0][GTC_DW-1:0] tc_w;
    logic [NT-1:0][GTC_DW-1:0] pc_w;
    logic [NT-1:0][NM-1:0] match_w;
    logic [NT-1:0] stop_w;

    // Output flops
    logic [NT*ND-1:0] dma_req_r;
    logic irq_r;

    // Only word transfers exist, so the size is not decoded
    assign acc = hsel & hready & (htrans == GTC_HTRANS_NONSEQ);
    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    // Every transfer completes without error
    assign hresp = GTC_HRESP_OKAY;
    assign dma_req = dma_req_r;
    assign irq = irq_r;
    assign rd_t = addr_r[GTC_TSEL_LSB+GTC_TSEL_W-1:GTC_TSEL_LSB];

    // Address and data phase tracking; reads take one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= '0;
            hreadyout_r <= 1'b1;
        end else if (ce) begin
            if (acc) begin
                wr_pend_r <= hwrite;
                rd_pend_r <= ~hwrite;
                addr_r <= haddr[GTC_ADDR_W-1:0];
                // Wait state lets a preceding write land first
                hreadyout_r <= hwrite;
            end else begin
                wr_pend_r <= 1'b0;
                rd_pend_r <= 1'b0;
                hreadyout_r <= 1'b1;
            end
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= GTC_RST_WORD;
        end else if (ce && rd_pend_r) begin
            hrdata_r <= rd_word;
        end
    end

    // Read mux over the addressed timer
    always_comb begin
        rd_word = GTC_RST_WORD;
        case (addr_r[GTC_OFF_W-1:0])
            GTC_OFF_CTRL: begin
                rd_word[GTC_CTRL_EN] = cfg_r[rd_t].enable;
                rd_word[GTC_CTRL_RST] = cfg_r[rd_t].cnt_rst;
                rd_word[GTC_CTRL_MODE] = cfg_r[rd_t].mode;
            end
            GTC_OFF_TC: rd_word = tc_w[rd_t];
            GTC_OFF_PR: rd_word = cfg_r[rd_t].prescale;
            GTC_OFF_PC: rd_word = pc_w[rd_t];
            GTC_OFF_MCR: rd_word[NM*GTC_MCR_W-1:0] = mcr_r[rd_t];
            GTC_OFF_CCR: rd_word[NC*GTC_CCR_W-1:0] = ccr_r[rd_t];
            GTC_OFF_EMR: rd_word[GTC_EMR_W-1:0] = emr_r[rd_t];
            GTC_OFF_DMAR: rd_word[ND-1:0] = dmar_r[rd_t];
            GTC_OFF_STATUS: rd_word[GTC_ST_W-1:0] = status_r[rd_t];
            GTC_OFF_MASK: rd_word[GTC_ST_W-1:0] = mask_r[rd_t];
            default: begin
                // Match and capture words; other holes read zero
                for (int i = 0; i < NM; i++) begin
                    if (addr_r[GTC_OFF_W-1:0] == grp_off(GTC_OFF_MR0, i)) begin
                        rd_word = mr_r[rd_t][i];
                    end
                end
                for (int c = 0; c < NC; c++) begin
                    if (addr_r[GTC_OFF_W-1:0] == grp_off(GTC_OFF_CR0, c)) begin
                        rd_word = cap_r[rd_t][c];
                    end
                end
            end
        endcase
    end

    // Capture and external clock pins are asynchronous
    gtc_sync #(
        .W(SW)
    ) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .ce(ce),
        .d({ext_clk_in, cap_in}),
        .q(pin_s)
    );

    // Previous synchronised level for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_prev_r <= '0;
        end else if (ce) begin
            pin_prev_r <= pin_s;
        end
    end

    assign pin_rise = pin_s & ~pin_prev_r;
    assign pin_fall = ~pin_s & pin_prev_r;

    // Summary interrupt over all unmasked pending flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(status_r & mask_r);
        end
    end

    genvar t;
    generate
        for (t = 0; t < NT; t++) begin : g_tmr
            localparam logic [GTC_TSEL_W-1:0] TID = GTC_TSEL_W'(t);
            logic [GTC_ST_W-1:0] st_set; // Events this cycle
            logic [GTC_ST_W-1:0] st_clr; // Read-clear this cycle
            logic [NC-1:0] cap_ev; // Capture events this cycle

            gtc_core #(
                .NM(NM)
            ) u_core (
                .clk(hclk),
                .rst_n(hresetn),
                .ce(ce),
                .cfg(cfg_r[t]),
                .mcr(mcr_r[t]),
                .ext_rise(pin_rise[NT*NC+t]),
                .mr(mr_r[t]),
                .tc_wr(wr_pend_r & reg_hit(addr_r, TID, GTC_OFF_TC)),
                .tc_wdata(hwdata),
                .tc_r(tc_w[t]),
                .pc_r(pc_w[t]),
                .match_ev(match_w[t]),
                .stop_ev(stop_w[t])
            );

            // Control and prescale; a halting match wins over software
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cfg_r[t] <= GTC_CFG_RST;
                end else if (ce) begin
                    if (wr_pend_r && reg_hit(addr_r, TID, GTC_OFF_CTRL)) begin
                        cfg_r[t].enable <= hwdata[GTC_CTRL_EN];
                        cfg_r[t].cnt_rst <= hwdata[GTC_CTRL_RST];
                        cfg_r[t].mode <= hwdata[GTC_CTRL_MODE];
                    end
                    if (wr_pend_r && reg_hit(addr_r, TID, GTC_OFF_PR)) begin
                        cfg_r[t].prescale <= hwdata;
                    end
                    if (stop_w[t]) begin
                        cfg_r[t].enable <= 1'b0;
                    end
                end
            end

            // Match registers
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mr_r[t] <= '0;
                end else if (ce && wr_pend_r) begin
                    for (int i = 0; i < NM; i++) begin
                        if (reg_hit(addr_r, TID, grp_off(GTC_OFF_MR0, i))) begin
                            mr_r[t][i] <= hwdata;
                        end
                    end
                end
            end

            // Match, capture and DMA selections, interrupt mask
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mcr_r[t] <= '0;
                    ccr_r[t] <= '0;
                    dmar_r[t] <= '0;
                    mask_r[t] <= '0;
                end else if (ce && wr_pend_r) begin
                    if (reg_hit(addr_r, TID, GTC_OFF_MCR)) begin
                        mcr_r[t] <= hwdata[NM*GTC_MCR_W-1:0];
                    end
                    if (reg_hit(addr_r, TID, GTC_OFF_CCR)) begin
                        ccr_r[t] <= hwdata[NC*GTC_CCR_W-1:0];
                    end
                    if (reg_hit(addr_r, TID, GTC_OFF_DMAR)) begin
                        dmar_r[t] <= hwdata[ND-1:0];
                    end
                    if (reg_hit(addr_r, TID, GTC_OFF_MASK)) begin
                        mask_r[t] <= hwdata[GTC_ST_W-1:0];
                    end
                end
            end

            // Match pin states; a match in the write cycle wins
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    emr_r[t] <= '0;
                end else if (ce) begin
                    if (wr_pend_r && reg_hit(addr_r, TID, GTC_OFF_EMR)) begin
                        emr_r[t] <= hwdata[GTC_EMR_W-1:0];
                    end
                    for (int i = 0; i < NM; i++) begin
                        if (match_w[t][i]) begin
                            case (gtc_act_e'(emr_r[t][GTC_EMR_ACT_LSB
                                    + i*GTC_EMR_ACT_W +: GTC_EMR_ACT_W]))
                                GTC_ACT_LOW: emr_r[t][i] <= 1'b0;
                                GTC_ACT_HIGH: emr_r[t][i] <= 1'b1;
                                GTC_ACT_TOGGLE: emr_r[t][i] <= ~emr_r[t][i];
                                default: ; // No action lets a write land
                            endcase
                        end
                    end
                end
            end

            assign match_out[t*NM +: NM] = emr_r[t][NM-1:0];

            for (genvar c = 0; c < NC; c++) begin : g_cap
                assign cap_ev[c] =
                    (pin_rise[t*NC+c] & ccr_r[t][c*GTC_CCR_W+GTC_CCR_RISE])
                    | (pin_fall[t*NC+c] & ccr_r[t][c*GTC_CCR_W+GTC_CCR_FALL]);
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cap_r[t] <= '0;
                end else if (ce) begin
                    for (int c = 0; c < NC; c++) begin
                        if (cap_ev[c]) begin
                            cap_r[t][c] <= tc_w[t];
                        end
                    end
                end
            end

            // capture and match flags feed the interrupt
            assign st_set = {cap_ev, match_w[t]};
            assign st_clr = (rd_pend_r
                && reg_hit(addr_r, TID, GTC_OFF_STATUS)) ? '1 : '0;

            // Pending flags; an event in the clearing read survives
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    status_r[t] <= '0;
                end else if (ce) begin
                    status_r[t] <= (status_r[t] & ~st_clr) | st_set;
                end
            end

            // One-cycle DMA request per enabled match
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    dma_req_r[t*ND +: ND] <= '0;
                end else if (ce) begin
                    dma_req_r[t*ND +: ND] <= match_w[t][ND-1:0] & dmar_r[t];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// >>> shared/gtc_pkg.sv
// Constants, types and register map for the four-way 32-bit timer/counter.
// Assumes a single hclk domain and word-only AHB-Lite register access.
package gtc_pkg;

    // Instance counts and data width
    localparam int GTC_NUM_TIMERS = 4;
    localparam int GTC_NUM_MATCH = 4;
    localparam int GTC_NUM_CAP = 2;
    localparam int GTC_NUM_DMA = 2;
    localparam int GTC_DW = 32;

    // Address split: timer select above a 64-byte block of 16 words
    localparam int GTC_ADDR_W = 8;
    localparam int GTC_TSEL_LSB = 6;
    localparam int GTC_TSEL_W = 2;
    localparam int GTC_OFF_W = 6;
    localparam int GTC_WORD_BYTES = 4;

    // Byte offsets inside one timer block
    localparam logic [5:0] GTC_OFF_CTRL = 6'h00;
    localparam logic [5:0] GTC_OFF_TC = 6'h04;
    localparam logic [5:0] GTC_OFF_PR = 6'h08;
    localparam logic [5:0] GTC_OFF_PC = 6'h0C;
    localparam logic [5:0] GTC_OFF_MR0 = 6'h10;
    localparam logic [5:0] GTC_OFF_CR0 = 6'h20;
    localparam logic [5:0] GTC_OFF_MCR = 6'h28;
    localparam logic [5:0] GTC_OFF_CCR = 6'h2C;
    localparam logic [5:0] GTC_OFF_EMR = 6'h30;
    localparam logic [5:0] GTC_OFF_DMAR = 6'h34;
    localparam logic [5:0] GTC_OFF_STATUS = 6'h38;
    localparam logic [5:0] GTC_OFF_MASK = 6'h3C;

    // Control word bits
    localparam int GTC_CTRL_EN = 0;
    localparam int GTC_CTRL_RST = 1;
    localparam int GTC_CTRL_MODE = 2;

    // Match control: two bits per match register
    localparam int GTC_MCR_RST = 0;
    localparam int GTC_MCR_STOP = 1;
    localparam int GTC_MCR_W = 2;

    // Capture control: two bits per capture channel
    localparam int GTC_CCR_RISE = 0;
    localparam int GTC_CCR_FALL = 1;
    localparam int GTC_CCR_W = 2;

    // External match word: states low, two action bits per output above
    localparam int GTC_EMR_ACT_LSB = 4;
    localparam int GTC_EMR_ACT_W = 2;
    localparam int GTC_EMR_W = 12;

    // Status and mask: match flags low, capture flags above
    localparam int GTC_ST_CAP_LSB = 4;
    localparam int GTC_ST_W = 6;

    // Reset value of every register
    localparam logic [31:0] GTC_RST_WORD = 32'h0000_0000;

    // AHB-Lite codes
    localparam logic [1:0] GTC_HTRANS_NONSEQ = 2'h2;
    localparam logic GTC_HRESP_OKAY = 1'h0;

    // Match output action
    typedef enum logic [1:0] {
        GTC_ACT_NONE = 2'h0,
        GTC_ACT_LOW = 2'h1,
        GTC_ACT_HIGH = 2'h2,
        GTC_ACT_TOGGLE = 2'h3
    } gtc_act_e;

    // Counting configuration handed to one core
    typedef struct packed {
        logic enable;
        logic cnt_rst;
        logic mode;
        logic [GTC_DW-1:0] prescale;
    } gtc_cfg_s;

    localparam gtc_cfg_s GTC_CFG_RST = '{1'h0, 1'h0, 1'h0, GTC_RST_WORD};

endpackage

// >>> verification/gtc_pins.sv
// Pin-side model: external count clock, capture pins, DMA pulse counter.
// Assumes the default four timers with two captures and two DMA lines each.
`timescale 1ns/1ps
`default_nettype none
module gtc_pins (
    input wire logic clk,
    input wire logic [7:0] dma_req,
    output logic [7:0] cap_in,
    output logic [3:0] ext_clk_in
);
    int dma_cnt = 0; // Pulses seen on timer 2 match 0
    initial begin
        cap_in = 8'h00;
        ext_clk_in = 4'h0;
    end
    always @(posedge clk) begin
        if (dma_req[4] === 1'b1)
            dma_cnt++;
    end
    // Slow external clock; stands low between bursts
    task ext_pulses(input int t, input int n);
        repeat (n) begin
            ext_clk_in[t] <= 1'b1;
            repeat (3) @(posedge clk);
            ext_clk_in[t] <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    // One level change on a capture pin, then settle
    task cap_set(input int b, input logic v);
        cap_in[b] <= v;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> verification/gtc_top_sva.sv
// Checker on the timer top's bus, pin and interrupt ports.
// Assumes one slave, hready looped from hreadyout, ce low only when idle.
`timescale 1ns/1ps
`default_nettype none
module gtc_top_sva #(
    parameter int NT = 4,
    parameter int NM = 4,
    parameter int ND = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic [NT*NM-1:0] match_out,
    input wire logic [NT*ND-1:0] dma_req,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic tk; // Transfer taken at this edge
    assign tk = hsel && hready && ce && htrans == 2'h2;
    sequence rd_s; tk && !hwrite; endsequence
    sequence wr_s; tk && hwrite; endsequence
    sequence wait_s; !hreadyout ##1 hreadyout; endsequence
    rd_wait_a: assert property (rd_s |=> wait_s)
        else $error("read wait state wrong");
    wr_nowait_a: assert property (wr_s |=> hreadyout)
        else $error("write stalled");
    ready_short_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait longer than one cycle");
    rd_hold_a: assert property (hreadyout |=> $stable(hrdata))
        else $error("read data moved outside a read");
    resp_okay_a: assert property (tk |=> !hresp [*2])
        else $error("response not okay");
    ce_freeze_a: assert property (!ce |=> $stable(match_out)
        && $stable(irq) && $stable(dma_req))
        else $error("outputs moved with ce low");
    dma_pulse_a: assert property (|dma_req |=>
        (dma_req & $past(dma_req)) == '0)
        else $error("dma request longer than a pulse");
    irq_drop_a: assert property ($fell(irq) |-> $past(tk, 3))
        else $error("irq dropped without a bus access");
endmodule
bind gtc_top gtc_top_sva #(.NT(NT), .NM(NM), .ND(ND)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .match_out(match_out), .dma_req(dma_req), .irq(irq)
);
`default_nettype wire

// >>> verification/tb.sv
// Bench for the four-way timer: AHB-Lite register tasks and pin scenarios.
// Assumes default sizes and the pin model beside the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("[ERR] %s exp %h got %h", nm, exp, got); \
    end \
end
module tb import gtc_pkg::*; ;
    logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] cap_in, dma_req;
    logic [3:0] ext_clk_in;
    logic [15:0] match_out;
    int compares = 0;
    int miscompares = 0;
    // Free-running 100 MHz clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    gtc_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .cap_in(cap_in),
        .ext_clk_in(ext_clk_in), .match_out(match_out),
        .dma_req(dma_req), .irq(irq)
    );
    gtc_pins u_pins (
        .clk(hclk), .dma_req(dma_req), .cap_in(cap_in),
        .ext_clk_in(ext_clk_in)
    );
    task final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // A wait that runs out counts as a mismatch and ends the run
    task tmo;
        miscompares++;
        final_report();
    endtask
    // Wait for hready at an edge; a hang ends the run
    task rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) tmo();
    endtask
    // One single word transfer, address phase then data phase
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= GTC_HTRANS_NONSEQ;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rdv = hrdata;
    endtask
    // Bounded wait for the interrupt line
    task wirq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge hclk);
            n++;
        end
        if (irq !== 1'b1) tmo();
    endtask
    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Every timer 0 word starts at zero
        for (int i = 0; i < 16; i++) begin
            xfer(1'b0, 8'(i * 4), 32'h0);
            `CHK("reset word", 32'h0, rdv)
        end
        // Stop on match 0 with prescale 1; other matches hit at zero
        xfer(1'b1, 8'h08, 32'h1);
        xfer(1'b1, 8'h10, 32'h3);
        xfer(1'b1, 8'h28, 32'h2);
        xfer(1'b1, 8'h3C, 32'h1);
        xfer(1'b1, 8'h00, 32'h1);
        wirq();
        `CHK("irq on match", 1'b1, irq)
        xfer(1'b0, 8'h04, 32'h0);
        `CHK("stopped count", 32'h3, rdv)
        xfer(1'b0, 8'h00, 32'h0);
        `CHK("enable cleared", 32'h0, rdv)
        xfer(1'b0, 8'h38, 32'h0);
        `CHK("status flags", 32'hF, rdv)
        xfer(1'b0, 8'h38, 32'h0);
        `CHK("status cleared", 32'h0, rdv)
        `CHK("irq cleared", 1'b0, irq)
        // Timer 1 wraps at match 0; prescale counter is read-only
        xfer(1'b1, 8'h50, 32'h2);
        xfer(1'b1, 8'h68, 32'h1);
        xfer(1'b1, 8'h40, 32'h1);
        ce <= 1'b0;
        repeat (3) @(posedge hclk);
        ce <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 8'h44, 32'h0);
            `CHK("count wraps", 1'b1, rdv < 32'h3)
        end
        // Halted first, so a landed write would stay in the counter
        xfer(1'b1, 8'h40, 32'h0);
        xfer(1'b1, 8'h4C, 32'hFFFF_FFFF);
        xfer(1'b0, 8'h4C, 32'h0);
        `CHK("prescale count", 32'h0, rdv)
        // Timer 2: every pin action, with DMA on match 0
        xfer(1'b1, 8'hB4, 32'h1);
        xfer(1'b1, 8'h90, 32'h1);
        xfer(1'b1, 8'hA8, 32'h2);
        for (int a = 0; a < 4; a++) begin
            xfer(1'b1, 8'h80, 32'h2);
            xfer(1'b1, 8'hB0, {26'h0, 2'(a), 3'h0, 1'(a != 2)});
            xfer(1'b1, 8'h80, 32'h1);
            // Poll at least once; the last read may be stale
            rdv = 32'h1;
            for (int i = 0; i < 20 && rdv[0] !== 1'b0; i++)
                xfer(1'b0, 8'h80, 32'h0);
            if (rdv[0] !== 1'b0) tmo();
            `CHK("pin action", 1'(a == 0 || a == 2), match_out[8])
        end
        `CHK("dma pulses", 4, u_pins.dma_cnt)
        // Timer 3 counts pin edges; channel 0 on rise, 1 on fall
        xfer(1'b1, 8'hEC, 32'h9);
        xfer(1'b1, 8'hFC, 32'h10);
        xfer(1'b1, 8'hC0, 32'h5);
        u_pins.ext_pulses(3, 5);
        xfer(1'b0, 8'hC4, 32'h0);
        `CHK("pin count", 32'h5, rdv)
        `CHK("masked matches", 1'b0, irq)
        u_pins.cap_set(6, 1'b1);
        wirq();
        `CHK("capture irq", 1'b1, irq)
        xfer(1'b0, 8'hE0, 32'h0);
        `CHK("capture value", 32'h5, rdv)
        // Channel 1 ignores its rise and latches on its fall
        u_pins.cap_set(7, 1'b1);
        u_pins.ext_pulses(3, 2);
        u_pins.cap_set(7, 1'b0);
        xfer(1'b0, 8'hE4, 32'h0);
        `CHK("fall capture", 32'h7, rdv)
        xfer(1'b0, 8'hF8, 32'h0);
        `CHK("timer 3 status", 32'h3F, rdv)
        final_report();
    end
endmodule
`default_nettype wire
